/* File: logic/sps_pkg.sv */
// constants shared by the serial status and interrupt block
package sps_pkg;

   // -----------------------------------------------------------------
   // register byte offsets
   // -----------------------------------------------------------------
   localparam logic [7:0]  OFF_CTRL   = 8'h00;
   localparam logic [7:0]  OFF_STATUS = 8'h14;
   localparam logic [7:0]  OFF_ICTL   = 8'h18;

   // -----------------------------------------------------------------
   // field positions
   // -----------------------------------------------------------------
   localparam int CTL_ENABLE   = 0;
   localparam int CTL_MODE     = 1;
   localparam int CTL_SS_DIR   = 8;
   localparam int CTL_SS_POL   = 9;

   localparam int ST_BUSY      = 6;
   localparam int ST_CONFLICT  = 5;
   localparam int ST_TX_EMPTY  = 4;
   localparam int ST_OVERRUN   = 3;
   localparam int ST_RX_FULL   = 2;

   localparam int IC_CONFLICT  = 5;
   localparam int IC_TX_EMPTY  = 4;
   localparam int IC_OVERRUN   = 3;
   localparam int IC_RX_FULL   = 2;
   localparam int IC_SOFT      = 1;
   localparam int IC_MASTER    = 0;

   // -----------------------------------------------------------------
   // reset values
   // -----------------------------------------------------------------
   localparam logic [31:0] RST_CTRL   = 32'h0000_0000;
   localparam logic [31:0] RST_STATUS = 32'h0000_0010;
   localparam logic [31:0] RST_ICTL   = 32'h0000_0000;

   // -----------------------------------------------------------------
   // transfer activity states
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {
      XF_IDLE = 2'b01,
      XF_BUSY = 2'b10
   } sps_xfer_e;

endpackage

/* File: logic/sps_apb.sv */
// apb slave front end with one wait state per access
`timescale 1ns/100ps
`default_nettype none

module sps_apb #(
   parameter int ADDR_W = 8
) (
   input  wire logic              clk_sys,
   input  wire logic              rst,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic              hit,
   input  wire logic [31:0]       rdata,
   output logic                   pready,
   output logic [31:0]            prdata,
   output logic                   pslverr,
   output logic                   wr_en,
   output logic                   rd_en
);

   logic access;

   // first access cycle waits, answer comes registered on the second
   assign access = psel & penable & ~pready;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pready <= 1'b0;
      end else begin
         pready <= access;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (access) begin
         prdata  <= (!pwrite && hit) ? rdata : 32'h0000_0000;
         pslverr <= ~hit;
      end else begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
   end

   // effects happen only at the completing edge
   assign wr_en = psel & penable & pready & pwrite & hit;
   assign rd_en = psel & penable & pready & ~pwrite & hit;

endmodule // sps_apb

`default_nettype wire

/* File: logic/sps_irq.sv */
// interrupt request combiner, registered output
`timescale 1ns/100ps
`default_nettype none

module sps_irq (
   input  wire logic              clk_sys,
   input  wire logic              rst,
   input  wire logic [4:0]        flags,
   input  wire logic [5:0]        ictl,
   input  wire logic              conflict_armed,
   output logic                   irq
);

   logic src;

   // flags: conflict, tx empty, overrun, rx full at bits 4 to 1, one below their ictl bit positions
   always_comb begin
      src = ictl[sps_pkg::IC_SOFT];
      // conflict source counts only in master with the pin as detector
      src = src | (flags[4] & ictl[sps_pkg::IC_CONFLICT] & conflict_armed);
      src = src | (flags[3] & ictl[sps_pkg::IC_TX_EMPTY]);
      src = src | (flags[2] & ictl[sps_pkg::IC_OVERRUN]);
      src = src | (flags[1] & ictl[sps_pkg::IC_RX_FULL]);
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= ictl[sps_pkg::IC_MASTER] & src;
      end
   end

endmodule // sps_irq

`default_nettype wire

/* File: logic/sps_top.sv */
// status flags, interrupt control and apb registers of the serial unit
//
// The APB slave port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none

// Operation
// - busy rises at transfer start, falls at end
// - busy reads zero in slave operation
// - conflict flag set by external select in master with the select pin as input
// - conflict with enable forces slave, outputs off
// - tx empty set at reset/load, cleared by write
// - overrun set on new word while full
// - rx full set on word, cleared by read
// - writing enable zero clears whole status
// - conflict enable works only in detect master
// - tx empty enable gates its source
// - overrun enable gates its source
// - rx full enable gates its source
// - soft request bit raises the interrupt
// - soft request ignored while master enable low
// - master enable gates the interrupt output
// - enable bit switches transfer circuitry on
// - mode bit selects slave or master
// - select pin direction: detect input or output
module sps_top #(
   parameter int ADDR_W = 8
) (
   input  wire logic              clk_sys,
   input  wire logic              rst,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              xfer_start,
   input  wire logic              xfer_done,
   input  wire logic              tx_data_write,
   input  wire logic              tx_shift_load,
   input  wire logic              rx_word_load,
   input  wire logic              rx_data_read,
   input  wire logic              ss_in,
   output logic                   unit_on,
   output logic                   master_mode,
   output logic                   ss_drive_out,
   output logic                   outputs_off,
   output logic                   irq
);

   // -----------------------------------------------------------------
   // bus decode
   // -----------------------------------------------------------------
   logic              hit;
   logic              wr_en;
   logic [31:0]       rdata;
   logic              ctrl_wr;
   logic              ictl_wr;
   logic              disable_wr;

   assign hit = (paddr == sps_pkg::OFF_CTRL) || (paddr == sps_pkg::OFF_STATUS)
              || (paddr == sps_pkg::OFF_ICTL);

   sps_apb #(
      .ADDR_W (ADDR_W)
   ) u_apb (
      .clk_sys (clk_sys),
      .rst     (rst),
      .psel    (psel),
      .penable (penable),
      .pwrite  (pwrite),
      .hit     (hit),
      .rdata   (rdata),
      .pready  (pready),
      .prdata  (prdata),
      .pslverr (pslverr),
      .wr_en   (wr_en),
      .rd_en   ()
   );

   assign ctrl_wr    = wr_en && (paddr == sps_pkg::OFF_CTRL);
   assign ictl_wr    = wr_en && (paddr == sps_pkg::OFF_ICTL);
   assign disable_wr = ctrl_wr && !pwdata[sps_pkg::CTL_ENABLE];

   // -----------------------------------------------------------------
   // control register
   // -----------------------------------------------------------------
   logic              enable_reg;
   logic              mode_reg;
   logic              ss_dir_reg;
   logic              ss_pol_reg;
   logic [5:0]        ictl_reg;
   logic              off_reg;
   logic              conflict_reg;
   logic              detect_mode;
   logic              ss_active;
   logic              cancel;

   // the pin detects conflicts only as an input in master operation
   assign detect_mode = mode_reg && !ss_dir_reg;
   assign ss_active   = ss_pol_reg ? ss_in : !ss_in;
   assign cancel      = conflict_reg && ictl_reg[sps_pkg::IC_CONFLICT] && detect_mode;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         enable_reg <= sps_pkg::RST_CTRL[sps_pkg::CTL_ENABLE];
         mode_reg   <= sps_pkg::RST_CTRL[sps_pkg::CTL_MODE];
         ss_dir_reg <= sps_pkg::RST_CTRL[sps_pkg::CTL_SS_DIR];
         ss_pol_reg <= sps_pkg::RST_CTRL[sps_pkg::CTL_SS_POL];
      end else begin
         if (ctrl_wr) begin
            enable_reg <= pwdata[sps_pkg::CTL_ENABLE];
            mode_reg   <= pwdata[sps_pkg::CTL_MODE];
            ss_dir_reg <= pwdata[sps_pkg::CTL_SS_DIR];
            ss_pol_reg <= pwdata[sps_pkg::CTL_SS_POL];
         end
         // a pending cancel overrides a simultaneous mode write
         if (cancel) begin
            mode_reg <= 1'b0;
         end
      end
   end

   // outputs stay off after a cancel until software asks for master again
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         off_reg <= 1'b0;
      end else if (cancel) begin
         off_reg <= 1'b1;
      end else if (ctrl_wr && pwdata[sps_pkg::CTL_MODE]) begin
         off_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ictl_reg <= sps_pkg::RST_ICTL[5:0];
      end else if (ictl_wr) begin
         ictl_reg <= pwdata[5:0];
      end
   end

   // -----------------------------------------------------------------
   // transfer activity
   // -----------------------------------------------------------------
   sps_pkg::sps_xfer_e xfer_reg;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         xfer_reg <= sps_pkg::XF_IDLE;
      end else if (disable_wr || !enable_reg) begin
         xfer_reg <= sps_pkg::XF_IDLE;
      end else begin
         unique case (xfer_reg)
            sps_pkg::XF_IDLE: begin
               if (xfer_start && mode_reg && !off_reg) begin
                  xfer_reg <= sps_pkg::XF_BUSY;
               end
            end
            sps_pkg::XF_BUSY: begin
               if (xfer_done) begin
                  xfer_reg <= sps_pkg::XF_IDLE;
               end
            end
            default: begin
               xfer_reg <= sps_pkg::XF_IDLE;
            end
         endcase
      end
   end

   // -----------------------------------------------------------------
   // status flags; a set wins over a read or write clear in the same cycle, a disable write clears first, a cancel clears the conflict first
   // -----------------------------------------------------------------
   logic              txe_reg;
   logic              rxf_reg;
   logic              ovr_reg;
   logic              busy_vis;
   logic [31:0]       status_word;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         conflict_reg <= sps_pkg::RST_STATUS[sps_pkg::ST_CONFLICT];
      end else if (disable_wr || cancel) begin
         conflict_reg <= 1'b0;
      end else if (enable_reg && detect_mode && ss_active) begin
         conflict_reg <= 1'b1;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         txe_reg <= sps_pkg::RST_STATUS[sps_pkg::ST_TX_EMPTY];
      end else if (disable_wr) begin
         txe_reg <= 1'b0;
      end else if (enable_reg && tx_shift_load) begin
         txe_reg <= 1'b1;
      end else if (tx_data_write) begin
         txe_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rxf_reg <= sps_pkg::RST_STATUS[sps_pkg::ST_RX_FULL];
      end else if (disable_wr) begin
         rxf_reg <= 1'b0;
      end else if (enable_reg && rx_word_load) begin
         rxf_reg <= 1'b1;
      end else if (rx_data_read) begin
         rxf_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ovr_reg <= sps_pkg::RST_STATUS[sps_pkg::ST_OVERRUN];
      end else if (disable_wr) begin
         ovr_reg <= 1'b0;
      end else if (enable_reg && rx_word_load && rxf_reg) begin
         ovr_reg <= 1'b1;
      end else if (rx_data_read) begin
         ovr_reg <= 1'b0;
      end
   end

   // busy is hidden whenever the unit is a slave
   assign busy_vis = (xfer_reg == sps_pkg::XF_BUSY) && mode_reg;

   always_comb begin
      status_word                       = 32'h0000_0000;
      status_word[sps_pkg::ST_BUSY]     = busy_vis;
      status_word[sps_pkg::ST_CONFLICT] = conflict_reg;
      status_word[sps_pkg::ST_TX_EMPTY] = txe_reg;
      status_word[sps_pkg::ST_OVERRUN]  = ovr_reg;
      status_word[sps_pkg::ST_RX_FULL]  = rxf_reg;
   end

   always_comb begin
      rdata = 32'h0000_0000;
      if (paddr == sps_pkg::OFF_STATUS) begin
         rdata = status_word;
      end else if (paddr == sps_pkg::OFF_ICTL) begin
         rdata[5:0] = ictl_reg;
      end else if (paddr == sps_pkg::OFF_CTRL) begin
         rdata[sps_pkg::CTL_ENABLE] = enable_reg;
         rdata[sps_pkg::CTL_MODE]   = mode_reg;
         rdata[sps_pkg::CTL_SS_DIR] = ss_dir_reg;
         rdata[sps_pkg::CTL_SS_POL] = ss_pol_reg;
      end
   end

   // -----------------------------------------------------------------
   // interrupt and outputs
   // -----------------------------------------------------------------
   sps_irq u_irq (
      .clk_sys        (clk_sys),
      .rst            (rst),
      .flags          ({conflict_reg, txe_reg, ovr_reg, rxf_reg, 1'b0}),
      .ictl           (ictl_reg),
      .conflict_armed (detect_mode),
      .irq            (irq)
   );

   assign unit_on      = enable_reg;
   assign master_mode  = mode_reg;
   assign ss_drive_out = ss_dir_reg;
   assign outputs_off  = off_reg;

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   AST_BUSY_START: assert property (
      (xfer_reg == sps_pkg::XF_IDLE) && xfer_start && mode_reg && !off_reg
      && enable_reg && !disable_wr |=> busy_vis || !mode_reg)
      else $error("busy did not rise at transfer start");

   AST_BUSY_DONE: assert property (
      (xfer_reg == sps_pkg::XF_BUSY) && xfer_done |=> (xfer_reg == sps_pkg::XF_IDLE))
      else $error("busy did not fall at transfer end");

   AST_BUSY_SLAVE: assert property (
      !mode_reg |-> !status_word[sps_pkg::ST_BUSY])
      else $error("busy visible in slave operation");

   AST_CONFLICT_SET: assert property (
      enable_reg && detect_mode && ss_active && !cancel && !disable_wr |=> conflict_reg)
      else $error("conflict flag not set");

   AST_CANCEL: assert property (
      cancel |=> !mode_reg && off_reg && !conflict_reg ##1 !conflict_reg)
      else $error("conflict cancel did not force slave");

   AST_TXE_CYCLE: assert property (
      enable_reg && tx_shift_load && !disable_wr
      |=> txe_reg)
      else $error("tx empty not restored after load");

   AST_TXE_CLEAR: assert property (
      tx_data_write && !(enable_reg && tx_shift_load) |=> !txe_reg)
      else $error("tx empty not cleared by write");

   AST_OVERRUN: assert property (
      enable_reg && rx_word_load && rxf_reg && !disable_wr |=> ovr_reg && rxf_reg)
      else $error("overrun not flagged");

   AST_RX_READ: assert property (
      rx_data_read && !rx_word_load |=> !rxf_reg && !ovr_reg)
      else $error("rx flags not cleared by read");

   AST_DISABLE: assert property (
      disable_wr |=> (status_word == 32'h0000_0000) && !unit_on)
      else $error("status not cleared on disable");

   AST_IRQ_MASTER: assert property (
      !ictl_reg[sps_pkg::IC_MASTER] |=> !irq)
      else $error("irq with master enable low");

   AST_IRQ_SOFT: assert property (
      ictl_reg[sps_pkg::IC_MASTER] && ictl_reg[sps_pkg::IC_SOFT] |=> irq)
      else $error("soft request did not raise irq");

   AST_IRQ_RXF: assert property (
      ictl_reg[0] && !ictl_reg[1] && !ictl_reg[4] && !ictl_reg[3] && !ictl_reg[5]
      |=> irq == $past(rxf_reg && ictl_reg[sps_pkg::IC_RX_FULL]))
      else $error("rx full source not gated");

   CV_TRANSFER: cover property (
      (xfer_reg == sps_pkg::XF_IDLE) ##1 busy_vis [*2] ##1 !busy_vis);
   CV_CANCEL:   cover property (cancel ##1 off_reg);
   CV_OVERRUN:  cover property (rxf_reg ##1 ovr_reg ##[1:20] rx_data_read);
   CV_IRQ:      cover property (!irq ##1 irq);

endmodule // sps_top

`default_nettype wire

/* File: sim/sps_ext_dev.sv */
// model of the external serial device that can claim the select pin
`timescale 1ns/100ps
`default_nettype none

module sps_ext_dev (
   input  wire logic clk_sys,
   input  wire logic rst,
   input  wire logic claim,
   input  wire logic active_high,
   output logic      ss_in
);
   // the pin never floats here: when not claiming, the device holds the inactive level
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ss_in <= 1'b1;
      end else begin
         ss_in <= claim ? active_high : ~active_high;
      end
   end
endmodule // sps_ext_dev

`default_nettype wire

/* File: sim/sps_tb.sv */
// self-checking testbench of the serial status and interrupt block
`timescale 1ns/100ps
`default_nettype none

module testbench;
   // -----------------------------------------------------------------
   // signals
   // -----------------------------------------------------------------
   logic        clk_sys, rst, psel, penable, pwrite, claim;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rdv;
   logic        pready, pslverr, errv, ss_in;
   logic        unit_on, master_mode, ss_drive_out, outputs_off, irq;
   logic [5:0]  ev;
   int          err_count, n_checks;
   logic [5:0]  ic_tab [8] = '{6'h10, 6'h11, 6'h09, 6'h05, 6'h21, 6'h03, 6'h02, 6'h01};
   logic        irq_tab [8] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
   // event pulse indices
   localparam int XS = 0, XD = 1, TW = 2, TL = 3, RL = 4, RR = 5;

   sps_top u_dut (
      .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .xfer_start(ev[XS]), .xfer_done(ev[XD]), .tx_data_write(ev[TW]),
      .tx_shift_load(ev[TL]), .rx_word_load(ev[RL]), .rx_data_read(ev[RR]),
      .ss_in(ss_in), .unit_on(unit_on), .master_mode(master_mode),
      .ss_drive_out(ss_drive_out), .outputs_off(outputs_off), .irq(irq)
   );

   sps_ext_dev u_dev (
      .clk_sys(clk_sys), .rst(rst), .claim(claim), .active_high(1'b0), .ss_in(ss_in)
   );

   // -----------------------------------------------------------------
   // tasks
   // -----------------------------------------------------------------
   task automatic give_verdict();
      if (err_count == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // one apb transfer; a dead slave is left to the watchdog
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
      end while (pready !== 1'b1);
      rdv = prdata;
      errv = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask

   task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      chk(name, rdv, exp);
   endtask

   task automatic pulse(input int k);
      @(posedge clk_sys);
      ev <= 6'h01 << k;
      @(posedge clk_sys);
      ev <= 6'h00;
      repeat (2) @(posedge clk_sys);
   endtask

   task automatic settle();
      repeat (4) @(posedge clk_sys);
   endtask

   // -----------------------------------------------------------------
   // clock, reset, watchdog
   // -----------------------------------------------------------------
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   initial begin
      repeat (20000) @(posedge clk_sys);
      err_count++;
      give_verdict();
   end

   // -----------------------------------------------------------------
   // tests
   // -----------------------------------------------------------------
   initial begin
      rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
      pwdata = 32'h0000_0000; ev = 6'h00; claim = 1'b0; err_count = 0; n_checks = 0;
      repeat (20) @(posedge clk_sys);
      rst <= 1'b0;
      rdchk("status", sps_pkg::OFF_STATUS, 32'h0000_0010);
      rdchk("irq_ctl", sps_pkg::OFF_ICTL, 32'h0000_0000);
      rdchk("unmapped", 8'h04, 32'h0000_0000);
      chk("pslverr", {31'h0, errv}, 32'h0000_0001);
      apb(1'b1, sps_pkg::OFF_STATUS, 32'h0000_00ff);
      rdchk("status_ro", sps_pkg::OFF_STATUS, 32'h0000_0010);
      chk("pslverr_ok", {31'h0, errv}, 32'h0000_0000);
      // master, select pin as conflict input, active low
      apb(1'b1, sps_pkg::OFF_CTRL, 32'h0000_0003);
      settle();
      chk("unit_on", {31'h0, unit_on}, 32'h0000_0001);
      chk("master_mode", {31'h0, master_mode}, 32'h0000_0001);
      chk("ss_drive_out", {31'h0, ss_drive_out}, 32'h0000_0000);
      pulse(XS);
      rdchk("busy_set", sps_pkg::OFF_STATUS, 32'h0000_0050);
      pulse(XD);
      rdchk("busy_clr", sps_pkg::OFF_STATUS, 32'h0000_0010);
      pulse(TW);
      rdchk("txe_clr", sps_pkg::OFF_STATUS, 32'h0000_0000);
      pulse(TL);
      rdchk("txe_set", sps_pkg::OFF_STATUS, 32'h0000_0010);
      pulse(RL);
      rdchk("rx_full", sps_pkg::OFF_STATUS, 32'h0000_0014);
      pulse(RL);
      rdchk("overrun", sps_pkg::OFF_STATUS, 32'h0000_001c);
      // every source is pending here except the conflict
      for (int i = 0; i < 8; i++) begin
         apb(1'b1, sps_pkg::OFF_ICTL, {26'h0, ic_tab[i]});
         settle();
         chk("irq", {31'h0, irq}, {31'h0, irq_tab[i]});
      end
      pulse(RR);
      rdchk("rx_read", sps_pkg::OFF_STATUS, 32'h0000_0010);
      apb(1'b1, sps_pkg::OFF_ICTL, 32'h0000_0000);
      // slave never shows busy
      apb(1'b1, sps_pkg::OFF_CTRL, 32'h0000_0001);
      pulse(XS);
      rdchk("slave_busy", sps_pkg::OFF_STATUS, 32'h0000_0010);
      pulse(XD);
      // select pin as output: a claim is not a conflict
      apb(1'b1, sps_pkg::OFF_CTRL, 32'h0000_0103);
      @(posedge clk_sys);
      claim <= 1'b1;
      settle();
      chk("ss_drive_out", {31'h0, ss_drive_out}, 32'h0000_0001);
      rdchk("ctrl_rd", sps_pkg::OFF_CTRL, 32'h0000_0103);
      rdchk("no_conflict", sps_pkg::OFF_STATUS, 32'h0000_0010);
      @(posedge clk_sys);
      claim <= 1'b0;
      apb(1'b1, sps_pkg::OFF_CTRL, 32'h0000_0003);
      @(posedge clk_sys);
      claim <= 1'b1;
      settle();
      rdchk("conflict", sps_pkg::OFF_STATUS, 32'h0000_0030);
      apb(1'b1, sps_pkg::OFF_ICTL, 32'h0000_0021);
      settle();
      chk("cancel_mode", {31'h0, master_mode}, 32'h0000_0000);
      chk("outputs_off", {31'h0, outputs_off}, 32'h0000_0001);
      @(posedge clk_sys);
      claim <= 1'b0;
      rdchk("cancel_flag", sps_pkg::OFF_STATUS, 32'h0000_0010);
      rdchk("ctrl_cancel", sps_pkg::OFF_CTRL, 32'h0000_0001);
      rdchk("ictl_rd", sps_pkg::OFF_ICTL, 32'h0000_0021);
      // disabling wipes the whole status word
      apb(1'b1, sps_pkg::OFF_CTRL, 32'h0000_0000);
      rdchk("disable", sps_pkg::OFF_STATUS, 32'h0000_0000);
      chk("unit_off", {31'h0, unit_on}, 32'h0000_0000);
      pulse(RL);
      rdchk("off_load", sps_pkg::OFF_STATUS, 32'h0000_0000);
      give_verdict();
   end
endmodule // testbench

`default_nettype wire
